// ---- servo_io_function_monitor.sv ----
// monitor and control-parameter logic of a servo driver, with an AXI4-Lite slave
// assumes: one 250 MHz clock; discrete inputs are asynchronous pins, loop status
// and feedback phases come from logic on the same clock
//
// What this block does
// [RQ1] feed-forward gain 0..1.0000, resets to 1.0000
// [RQ2] zero gain turns feed-forward path off
// [RQ3] input monitors show level after polarity and filter
// [RQ4] output monitors show state before timer and inversion
// [RQ5] hold monitor: 1 while hold requested
// [RQ6] integration-off monitor: 1 when integral disabled
// [RQ7] in-position only when done and target held
// [RQ8] jog monitor: 1 accelerate, 0 decelerate
// [RQ9] counter totals edges on both feedback phases
// [RQ10] writing zero clears counter, counting restarts
// [RQ11] first proximity monitor: 1 near target
// [RQ12] second proximity monitor: 1 near target
// [RQ13] normal monitor 0 on any alarm or warning
// [RQ14] bypass both torque filters at low speed
// [RQ15] zero threshold keeps filters always active
// [RQ16] override monitor: 1 when override active
// [RQ17] negative limit input monitor: 1 when detected
// [RQ18] positive limit input monitor: 1 when detected
// [RQ19] negative limit detect monitor: 1 when detected
// [RQ20] positive limit detect monitor: 1 when detected
// [RQ21] filtered level changes only after stable interval
// [RQ22] edge counter wraps, never saturates
`timescale 1ns/1ps
`default_nettype none
`include "servo_io_consts.svh"

module servo_io_function_monitor (
    // clock and reset
    input  wire logic                          i_clock,
    input  wire logic                          i_srst,
    // register bus
    input  wire servo_io_pkg::axi_req_type     i_axi,
    output var  servo_io_pkg::axi_rsp_type     o_axi,
    // discrete control pins, asynchronous
    input  wire logic                          i_hold_request_input,
    input  wire logic                          i_integration_disable_input,
    input  wire logic                          i_jog_request_input,
    input  wire logic                          i_velocity_override_input,
    input  wire logic                          i_neg_limit_input,
    input  wire logic                          i_pos_limit_input,
    // servo loop state
    input  wire servo_io_pkg::loop_status_type i_loop,
    input  wire logic                          i_feedback_phase_a,
    input  wire logic                          i_feedback_phase_b,
    input  wire logic [15:0]                   i_motor_speed,
    // servo loop controls
    output logic [13:0]                        o_feedforward_gain,
    output logic                               o_feedforward_enable,
    output logic                               o_torque_filter_bypass,
    output logic [5:0]                         o_input_monitor
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    servo_io_pkg::state_type s_q;
    servo_io_pkg::state_type s_d;

    logic [5:0]  pins;
    logic [5:0]  cand;
    logic [5:0]  loop_out;
    logic [31:0] mask;
    logic [31:0] wmerge;
    logic [31:0] old_val;
    logic [1:0]  edges;
    logic        do_write;
    logic        do_read;

    // pin gathering; bit order fixed by the input positions
    assign pins[`IN_HOLD]      = i_hold_request_input;
    assign pins[`IN_INTEG_OFF] = i_integration_disable_input;
    assign pins[`IN_JOG]       = i_jog_request_input;
    assign pins[`IN_OVERRIDE]  = i_velocity_override_input;
    assign pins[`IN_NEG_LIMIT] = i_neg_limit_input;
    assign pins[`IN_POS_LIMIT] = i_pos_limit_input;

    // raw servo outputs, taken before any stability timer or inversion
    assign loop_out[`OUT_IN_POSITION] = i_loop.positioning_done & i_loop.target_held; // see [RQ7]
    assign loop_out[`OUT_PROX_FIRST]  = i_loop.near_target_first;    // see [RQ11]
    assign loop_out[`OUT_PROX_SECOND] = i_loop.near_target_second;   // see [RQ12]
    assign loop_out[`OUT_NORMAL]      = ~(i_loop.alarm_active | i_loop.warning_active); // see [RQ13]
    assign loop_out[`OUT_NEG_DETECT]  = i_loop.neg_limit_detected;   // see [RQ19]
    assign loop_out[`OUT_POS_DETECT]  = i_loop.pos_limit_detected;   // see [RQ20]

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;

        // three-stage pin sampling; only stage two reads stage one
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.sync3 = s_q.sync2;

        // agreed level, polarity applied before filtering
        for (int i = 0; i < 6; i++) begin
            cand[i] = (s_q.sync2[i] == s_q.sync3[i]) ?
                      (s_q.sync3[i] ^ s_q.polarity[i]) : s_q.filt[i];
        end

        // anti-chatter: a new level waits out the interval first
        for (int i = 0; i < 6; i++) begin
            if (cand[i] == s_q.filt[i]) begin
                s_d.db_cnt[i] = 16'h0000;
            end else if (s_q.db_cnt[i] >= s_q.chatter_time) begin
                s_d.filt[i] = cand[i]; // see [RQ3] [RQ5] [RQ6] [RQ8] [RQ16] [RQ17] [RQ18] [RQ21]
                s_d.db_cnt[i] = 16'h0000;
            end else begin
                s_d.db_cnt[i] = s_q.db_cnt[i] + 16'h0001;
            end
        end

        // output monitors sample the raw loop state
        s_d.outmon = loop_out;                              // see [RQ4]

        // feedback edges on both phases, both may move at once
        edges = {1'b0, i_feedback_phase_a ^ s_q.phase_a} +
                {1'b0, i_feedback_phase_b ^ s_q.phase_b};
        s_d.phase_a  = i_feedback_phase_a;
        s_d.phase_b  = i_feedback_phase_b;
        s_d.edge_cnt = s_q.edge_cnt + {30'h0000_0000, edges}; // see [RQ9] [RQ22]

        // write channels are taken independently, in either order
        if (i_axi.awvalid && s_q.rsp.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = i_axi.awaddr;
        end
        if (i_axi.wvalid && s_q.rsp.wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata  = i_axi.wdata;
            s_d.wstrb  = i_axi.wstrb;
        end

        // byte-lane merge against the addressed register
        unique case (s_q.awaddr)
            `OFS_FF_GAIN:      old_val = {18'h00000, s_q.ff_gain};
            `OFS_FO_VEL:       old_val = {18'h00000, s_q.fo_vel};
            `OFS_IN_POLARITY:  old_val = {26'h0000000, s_q.polarity};
            `OFS_CHATTER_TIME: old_val = {16'h0000, s_q.chatter_time};
            `OFS_EDGE_COUNT:   old_val = s_q.edge_cnt;
            default:           old_val = 32'h0000_0000;
        endcase
        mask   = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}},
                  {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
        wmerge = (old_val & ~mask) | (s_q.wdata & mask);

        // perform the write once address and data are both held
        do_write = s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid;
        if (do_write) begin
            s_d.aw_held   = 1'b0;
            s_d.w_held    = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = `RESP_OKAY;
            unique case (s_q.awaddr)
                `OFS_FF_GAIN: begin
                    // out-of-range gain is refused, old value kept
                    if (wmerge <= {18'h00000, `FF_GAIN_MAX}) begin
                        s_d.ff_gain = wmerge[13:0];          // see [RQ1]
                    end else begin
                        s_d.rsp.bresp = `RESP_SLVERR;
                    end
                end
                `OFS_FO_VEL: begin
                    if (wmerge <= {18'h00000, `FO_VEL_MAX}) begin
                        s_d.fo_vel = wmerge[13:0];           // see [RQ14]
                    end else begin
                        s_d.rsp.bresp = `RESP_SLVERR;
                    end
                end
                `OFS_IN_POLARITY:  s_d.polarity     = wmerge[5:0];
                `OFS_CHATTER_TIME: s_d.chatter_time = wmerge[15:0];
                // a load restarts counting; an edge in the same cycle still counts
                `OFS_EDGE_COUNT:   s_d.edge_cnt = wmerge + {30'h0000_0000, edges}; // see [RQ10]
                // monitors are read-only, unmapped space errors
                default:           s_d.rsp.bresp = `RESP_SLVERR;
            endcase
        end
        if (s_q.rsp.bvalid && i_axi.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end

        // read: one access in flight, data ready the cycle after the address
        do_read = i_axi.arvalid && s_q.rsp.arready;
        if (do_read) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rresp  = `RESP_OKAY;
            unique case (i_axi.araddr)
                `OFS_FF_GAIN:      s_d.rsp.rdata = {18'h00000, s_q.ff_gain};
                `OFS_FO_VEL:       s_d.rsp.rdata = {18'h00000, s_q.fo_vel};
                `OFS_IN_POLARITY:  s_d.rsp.rdata = {26'h0000000, s_q.polarity};
                `OFS_CHATTER_TIME: s_d.rsp.rdata = {16'h0000, s_q.chatter_time};
                `OFS_IN_MONITOR:   s_d.rsp.rdata = {26'h0000000, s_q.filt};   // see [RQ3]
                `OFS_OUT_MONITOR:  s_d.rsp.rdata = {26'h0000000, s_q.outmon}; // see [RQ4]
                `OFS_EDGE_COUNT:   s_d.rsp.rdata = s_q.edge_cnt;              // see [RQ9]
                default: begin
                    s_d.rsp.rdata = 32'h0000_0000;
                    s_d.rsp.rresp = `RESP_SLVERR;
                end
            endcase
        end else if (s_q.rsp.rvalid && i_axi.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end

        // readies registered from the next holding state
        s_d.rsp.awready = !s_d.aw_held;
        s_d.rsp.wready  = !s_d.w_held;
        s_d.rsp.arready = !s_d.rsp.rvalid;

        // loop controls follow the registered parameters
        s_d.ff_en  = (s_d.ff_gain != 14'h0000);             // see [RQ2]
        // zero threshold never bypasses; equal speed does
        s_d.bypass = (s_d.fo_vel != 14'h0000) &&
                     ({2'b00, s_d.fo_vel} >= i_motor_speed); // see [RQ14] [RQ15]
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            s_q              <= '0;
            s_q.ff_gain      <= `FF_GAIN_RESET;               // see [RQ1]
            s_q.ff_en        <= 1'b1;
            s_q.fo_vel       <= `FO_VEL_RESET;                // see [RQ15]
            s_q.polarity     <= `POLARITY_RESET;
            s_q.chatter_time <= `CHATTER_RESET;
            s_q.edge_cnt     <= `EDGE_RESET;
            s_q.rsp.awready  <= 1'b1;
            s_q.rsp.wready   <= 1'b1;
            s_q.rsp.arready  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign o_axi                  = s_q.rsp;
    assign o_feedforward_gain     = s_q.ff_gain;
    assign o_feedforward_enable   = s_q.ff_en;
    assign o_torque_filter_bypass = s_q.bypass;
    assign o_input_monitor        = s_q.filt;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [15:0] spd_q;
    // speed one cycle back
    always_ff @(posedge i_clock) begin
        spd_q <= i_motor_speed;
    end

    gain_reset_a: assert property (@(posedge i_clock) // see [RQ1]
        $fell(i_srst) |-> o_feedforward_gain == `FF_GAIN_RESET && o_feedforward_enable)
        else $error("gain not at full value after reset");

    ff_off_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ2]
        o_feedforward_enable == (o_feedforward_gain != 14'h0000))
        else $error("feed-forward enable disagrees with gain");

    gain_range_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ1]
        o_feedforward_gain <= `FF_GAIN_MAX)
        else $error("gain above full value");

    bypass_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ14]
        s_q.fo_vel != 14'h0000 |-> o_torque_filter_bypass == ({2'b00, s_q.fo_vel} >= spd_q))
        else $error("filter bypass wrong for speed");

    never_bypass_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ15]
        s_q.fo_vel == 14'h0000 |-> !o_torque_filter_bypass)
        else $error("filter bypassed with zero threshold");

    in_pos_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ7]
        !(i_loop.positioning_done && i_loop.target_held)
        |=> !s_q.outmon[`OUT_IN_POSITION])
        else $error("in-position set while not settled");

    normal_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ13]
        (i_loop.alarm_active || i_loop.warning_active) |=> !s_q.outmon[`OUT_NORMAL])
        else $error("normal shown during alarm");

    edge_step_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ9] [RQ22]
        (!do_write && edges == 2'h1) |=> s_q.edge_cnt == $past(s_q.edge_cnt) + 32'h1)
        else $error("edge counter missed a step");

    edge_clear_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ10]
        (do_write && s_q.awaddr == `OFS_EDGE_COUNT && wmerge == 32'h0 && edges == 2'h0)
        |=> s_q.edge_cnt == 32'h0)
        else $error("edge counter not cleared");

    chatter_a: assert property (@(posedge i_clock) disable iff (i_srst) // see [RQ21] [RQ3]
        (s_q.filt[0] != cand[0] && s_q.db_cnt[0] < s_q.chatter_time)
        |=> $stable(s_q.filt[0]))
        else $error("filtered level changed early");

endmodule : servo_io_function_monitor
`default_nettype wire

// ---- servo_io_consts.svh ----
// register offsets, field positions, reset values and limits of the monitor block
// assumes: included by bare name from the package and the design file
`ifndef SERVO_IO_CONSTS_SVH
`define SERVO_IO_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define OFS_FF_GAIN      8'h00
`define OFS_FO_VEL       8'h04
`define OFS_IN_POLARITY  8'h08
`define OFS_CHATTER_TIME 8'h0C
`define OFS_IN_MONITOR   8'h10
`define OFS_OUT_MONITOR  8'h14
`define OFS_EDGE_COUNT   8'h18

// ------------------------------------------------------------
// reset values and legal ranges
// ------------------------------------------------------------
`define FF_GAIN_RESET    14'h2710
`define FF_GAIN_MAX      14'h2710
`define FO_VEL_RESET     14'h0000
`define FO_VEL_MAX       14'h2710
`define POLARITY_RESET   6'h00
`define CHATTER_RESET    16'h0010
`define EDGE_RESET       32'h0000_0000

// ------------------------------------------------------------
// discrete input bit positions
// ------------------------------------------------------------
`define IN_HOLD          0
`define IN_INTEG_OFF     1
`define IN_JOG           2
`define IN_OVERRIDE      3
`define IN_NEG_LIMIT     4
`define IN_POS_LIMIT     5

// ------------------------------------------------------------
// servo output bit positions
// ------------------------------------------------------------
`define OUT_IN_POSITION  0
`define OUT_PROX_FIRST   1
`define OUT_PROX_SECOND  2
`define OUT_NORMAL       3
`define OUT_NEG_DETECT   4
`define OUT_POS_DETECT   5

// ------------------------------------------------------------
// bus answer codes
// ------------------------------------------------------------
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ---- servo_io_pkg.sv ----
// types shared by the monitor block and its bench
// assumes: servo_io_consts.svh sits in the same folder
`include "servo_io_consts.svh"

package servo_io_pkg;

    // ------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axi_rsp_type;

    // ------------------------------------------------------------
    // servo loop status feeding the output monitors
    // ------------------------------------------------------------
    typedef struct packed {
        logic positioning_done;
        logic target_held;
        logic near_target_first;
        logic near_target_second;
        logic alarm_active;
        logic warning_active;
        logic neg_limit_detected;
        logic pos_limit_detected;
    } loop_status_type;

    // ------------------------------------------------------------
    // whole state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0]       sync1;
        logic [5:0]       sync2;
        logic [5:0]       sync3;
        logic [5:0]       filt;
        logic [5:0][15:0] db_cnt;
        logic [5:0]       outmon;
        logic             phase_a;
        logic             phase_b;
        logic [31:0]      edge_cnt;
        logic [13:0]      ff_gain;
        logic             ff_en;
        logic [13:0]      fo_vel;
        logic             bypass;
        logic [5:0]       polarity;
        logic [15:0]      chatter_time;
        logic             aw_held;
        logic [7:0]       awaddr;
        logic             w_held;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        axi_rsp_type      rsp;
    } state_type;

endpackage : servo_io_pkg

// ---- servo_encoder_model.sv ----
// quadrature feedback source standing in for the servo loop's encoder
// assumes: stepped by the bench on the block's clock; one step moves one phase
`timescale 1ns/1ps
`default_nettype none

module servo_encoder_model (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_srst,
    // step request from the bench
    input  wire logic i_step,
    input  wire logic i_reverse,
    // feedback phases
    output logic      o_phase_a,
    output logic      o_phase_b
);
    logic [1:0] pos_q;
    logic [1:0] pos_d;

    // ------------------------------------------------------------
    // binary position, gray-coded at the phases
    // ------------------------------------------------------------
    // gray code so a step never moves both phases
    always_comb begin
        pos_d = pos_q;
        if (i_step) begin
            pos_d = i_reverse ? pos_q - 2'h1 : pos_q + 2'h1;
        end
    end

    // position register, cleared with the block
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            pos_q <= 2'h0;
        end else begin
            pos_q <= pos_d;
        end
    end

    // phases gray-encoded from the binary position
    assign o_phase_a = pos_q[1];
    assign o_phase_b = pos_q[1] ^ pos_q[0];
endmodule : servo_encoder_model
`default_nettype wire

// ---- servo_io_function_monitor_tb_top.sv ----
// self-checking bench for the servo monitor block
// assumes: package, block and encoder model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "servo_io_consts.svh"

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end

module servo_io_function_monitor_tb_top;
    typedef struct packed {
        logic [7:0] loop;
        logic [5:0] pins;
        logic [5:0] pol;
        logic [5:0] exp_out;
        logic [5:0] exp_in;
    } row_type;

    logic                          i_clock = 1'b0;
    logic                          i_srst  = 1'b1;
    servo_io_pkg::axi_req_type     bus_req = '0;
    servo_io_pkg::axi_rsp_type     bus_rsp;
    servo_io_pkg::loop_status_type loop_st = '0;
    logic [5:0]                    pins    = 6'h00;
    logic [15:0]                   speed   = 16'h0000;
    logic                          step    = 1'b0;
    logic                          reverse = 1'b0;
    logic                          phase_a;
    logic                          phase_b;
    logic [13:0]                   ff_gain;
    logic                          ff_en;
    logic                          bypass;
    logic [5:0]                    in_mon;
    logic [31:0]                   rdata;
    logic [1:0]                    resp;
    int                            n_fail = 0;
    int                            n_compared = 0;
    // loop status, pins, polarity, expected output and input monitors
    row_type                       rows [9] = '{
        '{8'hC0, 6'h01, 6'h00, 6'h09, 6'h01},
        '{8'h80, 6'h02, 6'h00, 6'h08, 6'h02},
        '{8'h40, 6'h04, 6'h00, 6'h08, 6'h04},
        '{8'h20, 6'h08, 6'h00, 6'h0A, 6'h08},
        '{8'h10, 6'h10, 6'h00, 6'h0C, 6'h10},
        '{8'h08, 6'h20, 6'h00, 6'h00, 6'h20},
        '{8'h04, 6'h00, 6'h3F, 6'h00, 6'h3F},
        '{8'h02, 6'h3F, 6'h3F, 6'h18, 6'h00},
        '{8'h01, 6'h00, 6'h00, 6'h28, 6'h00}};

    // ------------------------------------------------------------
    // clock, block and far side
    // ------------------------------------------------------------
    // free-running 250 MHz clock
    always #2 i_clock = ~i_clock;

    servo_io_function_monitor servo_io_function_monitor_i (
        .i_clock                     (i_clock),
        .i_srst                      (i_srst),
        .i_axi                       (bus_req),
        .o_axi                       (bus_rsp),
        .i_hold_request_input        (pins[0]),
        .i_integration_disable_input (pins[1]),
        .i_jog_request_input         (pins[2]),
        .i_velocity_override_input   (pins[3]),
        .i_neg_limit_input           (pins[4]),
        .i_pos_limit_input           (pins[5]),
        .i_loop                      (loop_st),
        .i_feedback_phase_a          (phase_a),
        .i_feedback_phase_b          (phase_b),
        .i_motor_speed               (speed),
        .o_feedforward_gain          (ff_gain),
        .o_feedforward_enable        (ff_en),
        .o_torque_filter_bypass      (bypass),
        .o_input_monitor             (in_mon)
    );

    servo_encoder_model servo_encoder_model_i (
        .i_clock   (i_clock),
        .i_srst    (i_srst),
        .i_step    (step),
        .i_reverse (reverse),
        .o_phase_a (phase_a),
        .o_phase_b (phase_b)
    );

    // ------------------------------------------------------------
    // bus master tasks
    // ------------------------------------------------------------
    // each valid held until its ready; an idle edge ends every call
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bus_req.awaddr  <= a;
        bus_req.awvalid <= 1'b1;
        bus_req.wdata   <= d;
        bus_req.wstrb   <= 4'hF;
        bus_req.wvalid  <= 1'b1;
        bus_req.bready  <= 1'b1;
        do begin
            @(posedge i_clock);
            if (bus_rsp.awready) bus_req.awvalid <= 1'b0;
            if (bus_rsp.wready) bus_req.wvalid <= 1'b0;
        end while (!bus_rsp.bvalid);
        r = bus_rsp.bresp;
        bus_req.bready <= 1'b0;
        @(posedge i_clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bus_req.araddr  <= a;
        bus_req.arvalid <= 1'b1;
        bus_req.rready  <= 1'b1;
        do begin
            @(posedge i_clock);
            if (bus_rsp.arready) bus_req.arvalid <= 1'b0;
        end while (!bus_rsp.rvalid);
        d = bus_rsp.rdata;
        r = bus_rsp.rresp;
        bus_req.rready <= 1'b0;
        @(posedge i_clock);
    endtask : rd

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        wr(a, d, resp);
        `CHK("bresp", e, resp)
    endtask : wr_chk

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a, rdata, resp);
        `CHK(nm, e, rdata)
        `CHK("rresp", `RESP_OKAY, resp)
    endtask : rd_chk

    // step the encoder n edges, then let the counter catch up
    task automatic run_steps(input int n, input logic rev);
        reverse <= rev;
        step    <= 1'b1;
        repeat (n) @(posedge i_clock);
        step <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask : run_steps

    task automatic final_report;
        $display("counts: %0d compared, %0d mismatched", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    // main sequence: reset values, monitor table, then awkward cases
    initial begin
        repeat (3) @(posedge i_clock);
        i_srst <= 1'b0;
        @(posedge i_clock);
        `CHK("gain", 14'h2710, ff_gain)
        `CHK("bypass", 1'b0, bypass)
        rd_chk("gain_reg", `OFS_FF_GAIN, 32'h0000_2710);
        rd_chk("fo_reg", `OFS_FO_VEL, 32'h0000_0000);
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            wr_chk(`OFS_IN_POLARITY, {26'h0, rows[k].pol}, `RESP_OKAY);
            pins    <= rows[k].pins;
            loop_st <= servo_io_pkg::loop_status_type'(rows[k].loop);
            repeat (40) @(posedge i_clock);
            `CHK("in_mon", rows[k].exp_in, in_mon)
            rd_chk("in_reg", `OFS_IN_MONITOR, {26'h0, rows[k].exp_in});
            rd_chk("out_reg", `OFS_OUT_MONITOR, {26'h0, rows[k].exp_out});
        end
        $display("test table done");
        // a pulse shorter than the filter interval is swallowed
        pins[0] <= 1'b1;
        repeat (8) @(posedge i_clock);
        pins[0] <= 1'b0;
        repeat (40) @(posedge i_clock);
        `CHK("glitch", 6'h00, in_mon)
        pins[0] <= 1'b1;
        repeat (12) @(posedge i_clock);
        `CHK("early", 6'h00, in_mon)
        repeat (30) @(posedge i_clock);
        `CHK("settled", 6'h01, in_mon)
        $display("test debounce done");
        wr_chk(`OFS_FF_GAIN, 32'h0, `RESP_OKAY);
        repeat (2) @(posedge i_clock);
        `CHK("ff_en", 1'b0, ff_en)
        wr_chk(`OFS_FF_GAIN, 32'h2711, `RESP_SLVERR);
        rd_chk("gain_reg", `OFS_FF_GAIN, 32'h0);
        wr_chk(`OFS_FF_GAIN, 32'h2710, `RESP_OKAY);
        repeat (2) @(posedge i_clock);
        `CHK("ff_en", 1'b1, ff_en)
        $display("test gain done");
        wr_chk(`OFS_FO_VEL, 32'h3E8, `RESP_OKAY);
        speed <= 16'h03E8;
        repeat (3) @(posedge i_clock);
        `CHK("bypass", 1'b1, bypass)
        speed <= 16'h03E9;
        repeat (3) @(posedge i_clock);
        `CHK("bypass", 1'b0, bypass)
        wr_chk(`OFS_FO_VEL, 32'h2711, `RESP_SLVERR);
        speed <= 16'h0000;
        repeat (3) @(posedge i_clock);
        `CHK("bypass", 1'b1, bypass)
        wr_chk(`OFS_FO_VEL, 32'h0, `RESP_OKAY);
        `CHK("bypass", 1'b0, bypass)
        $display("test bypass done");
        run_steps(10, 1'b0);
        rd_chk("edges", `OFS_EDGE_COUNT, 32'h0000_000A);
        // the operator clears the counter before measuring
        wr_chk(`OFS_EDGE_COUNT, 32'h0, `RESP_OKAY);
        run_steps(3, 1'b1);
        rd_chk("edges", `OFS_EDGE_COUNT, 32'h0000_0003);
        wr_chk(`OFS_EDGE_COUNT, 32'hFFFF_FFFF, `RESP_OKAY);
        run_steps(3, 1'b0);
        rd_chk("edges", `OFS_EDGE_COUNT, 32'h0000_0002);
        $display("test edges done");
        rd(8'h1C, rdata, resp);
        `CHK("unmapped", `RESP_SLVERR, resp)
        wr_chk(`OFS_OUT_MONITOR, 32'h3F, `RESP_SLVERR);
        rd_chk("out_reg", `OFS_OUT_MONITOR, 32'h0000_0028);
        $display("test refusals done");
        final_report();
    end

    // watchdog: the whole sequence needs about 700 cycles
    initial begin
        repeat (20000) @(posedge i_clock);
        n_fail++;
        final_report();
    end
endmodule : servo_io_function_monitor_tb_top
`default_nettype wire
